// [rtl/strap_defs.svh]
// Constant definitions for the reset strap configuration latch.
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
`define ADDR_STATUS        5'h00
`define ADDR_PORT_CFG      5'h04
`define ADDR_SWITCH_CFG    5'h08
`define ADDR_PINCTRL_CFG   5'h0c
`define ADDR_OVERRIDE      5'h10
`define ADDR_ID            5'h14
`define STATUS_LATCHED_BIT 0
`define STATUS_RSVD_BIT    1
`define PORT_AN_LSB        0
`define PORT_SPEED_LSB     8
`define PORT_DUPLEX_LSB    16
`define SW_BACKOFF_BIT     0
`define SW_RETRY_BIT       1
`define SW_FLOW_BIT        2
`define SW_BCAST_BIT       3
`define SW_BUFSHARE_BIT    4
`define SW_AGING_BIT       5
`define SW_FRAMELEN_BIT    6
`define SW_BACKPR_BIT      7
`define SW_P9_SPEED_BIT    8
`define SW_P9_DUPLEX_BIT   9
`define SW_P9_FLOW_BIT     10
`define PC_TAGPRI_BIT      0
`define PC_IFSEL_LSB       1
`define PC_PRIORITY_BUFFER_RESERVE_BIT        3
`define PC_PROGIF_BIT      4
`define PC_XOVER_BIT       5
`define PC_FEF_DIS_BIT     6
`define OV_TAGPRI_EN_BIT   0
`define OV_TAGPRI_VAL_BIT  1
`define OV_PRIORITY_BUFFER_RESERVE_EN_BIT     2
`define OV_PRIORITY_BUFFER_RESERVE_VAL_BIT    3
`define RETRY_LIMIT        5'h10
`define BCAST_LIMIT_PCT    7'h05
`define BUF_EQUAL          10'h071
`define BUF_SHARED         10'h200
`define AGING_MINUTES      4'h5
`define FRAME_MAX_TAGGED   11'h5f2
`define FRAME_MAX_UNTAGGED 11'h5ee
`define FRAME_MAX_LONG     11'h600
`define PRIORITY_BUFFER_RESERVE_KBYTES        4'h6
`define PRI_HIGH_MIN       3'h4
// The identification value is arbitrary.
`define DEVICE_ID          32'h00c0_ffee
`endif

// [rtl/strap_pkg.sv]
// Types shared by the reset strap configuration latch.
package strap_pkg;
   typedef enum logic [1:0]
   {
      IF_DISABLED = 2'b00,
      IF_REVERSE  = 2'b01,
      IF_FORWARD  = 2'b10,
      IF_SERIAL7  = 2'b11
   } port9_if_t;
   typedef enum logic [1:0]
   {
      ST_RESET   = 2'b00,
      ST_SETTLE  = 2'b01,
      ST_RUN     = 2'b10
   } latch_state_t;
endpackage

// [rtl/strap_sync.sv]
// Two-stage synchroniser for a vector of strap pins.
`timescale 1ns/100ps
module strap_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // The first stage feeds only the second; resets to all ones, the idle strap level.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// [rtl/reset_strap_config_latch.sv]
// Reset-time strap capture with an Avalon-MM register view of the result.
`timescale 1ns/100ps
`include "strap_defs.svh"
// Summary of operation
// - Ports 1-8 auto-negotiation straps low disable, high enable negotiation.
// - Speed straps low give 10 Mbps, high 100; only with negotiation off.
// - Duplex straps low give full duplex; used when negotiation off or unanswered.
// - Backoff strap low gives gentler back-off, high more aggressive.
// - Retry strap low drops frame after 16 collisions, high retries forever.
// - Flow-control strap low disables switch flow control, high enables.
// - Broadcast strap low limits broadcast to five percent, high unlimited.
// - Buffer strap low gives 113 buffers each, high shares up to 512.
// - Aging strap low disables aging, high ages at five minutes.
// - Frame strap low caps 1522/1518 bytes, high allows 1536 bytes.
// - Back-pressure strap low disables half-duplex back pressure, high enables.
// - Port 9 speed strap low gives 10 Mbps, high 100 Mbps.
// - Port 9 duplex strap low gives half duplex, high full duplex.
// - Port 9 flow strap low enables flow control, high disables.
// - Tag priority input picks EEPROM or tag priority; EEPROM overrides; 4-7 high.
// - Port 9 select: 00 off, 01 reverse, 10 forward, 11 seven-wire.
// - Priority reserve input 1 reserves 6KB; EEPROM setting overrides it.
// - Programming select 0 is processor, 1 EEPROM or unused serial lines.
// - Crossover input high enables automatic pair swap, low disables it.
// - Fault input high disables far-end-fault signalling, else normal.
// - Straps sampled only in reset; low is alternative, float or high default.
// - Shared pins are inputs during reset, driven only after sampling ends.
module reset_strap_config_latch #(
   // DEVICE_ID defaults to an arbitrary identification value.
   parameter int          PORTS     = 8,
   parameter int          SETTLE    = 2,
   parameter logic [31:0] DEVICE_ID = `DEVICE_ID
) (
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  wire logic [PORTS-1:0]   strap_an,
   input  wire logic [PORTS-1:0]   strap_speed,
   input  wire logic [PORTS-1:0]   strap_duplex,
   input  wire logic               strap_backoff_aggr,
   input  wire logic               strap_collision_retry,
   input  wire logic               strap_flow_ctrl,
   input  wire logic               strap_bcast_storm,
   input  wire logic               strap_buffer_share,
   input  wire logic               strap_addr_aging,
   input  wire logic               strap_frame_len,
   input  wire logic               strap_back_pressure,
   input  wire logic               strap_p9_speed,
   input  wire logic               strap_p9_duplex,
   input  wire logic               strap_p9_flow,
   input  wire logic               strap_p9_reserved,
   input  wire logic               tag_priority_enable,
   input  wire logic [1:0]         port9_if_select,
   input  wire logic               priority_buffer_reserve,
   input  wire logic               prog_if_select,
   input  wire logic               crossover_enable,
   input  wire logic               far_end_fault,
   input  wire logic [PORTS-1:0]   partner_negotiates,
   input  wire logic [4:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   output logic      [1:0]         avs_response,
   output logic                    strap_pins_oe,
   output logic                    config_valid,
   output logic      [PORTS-1:0]   port_an_en,
   output logic      [PORTS-1:0]   port_speed_100,
   output logic      [PORTS-1:0]   port_full_duplex,
   output logic                    backoff_aggressive,
   output logic                    retry_unlimited,
   output logic      [4:0]         collision_limit,
   output logic                    flow_ctrl_en,
   output logic                    bcast_unlimited,
   output logic      [6:0]         bcast_limit_pct,
   output logic      [9:0]         buffers_per_port,
   output logic                    aging_en,
   output logic      [3:0]         aging_minutes,
   output logic      [10:0]        frame_max_tagged,
   output logic      [10:0]        frame_max_untagged,
   output logic                    back_pressure_en,
   output logic                    p9_speed_100,
   output logic                    p9_full_duplex,
   output logic                    p9_flow_en,
   output logic                    p9_reserved_mode,
   output logic                    tag_priority_use,
   output logic      [2:0]         priority_high_min,
   output strap_pkg::port9_if_t    port9_mode,
   output logic                    seven_wire_serial_if,
   output logic      [3:0]         priority_reserve_kb,
   output logic                    prog_if_eeprom,
   output logic                    crossover_auto,
   output logic                    far_end_fault_dis
);
   // Nineteen single straps sit above the three per-port groups.
   localparam int NSTRAP = 3 * PORTS + 19;

   // Pins packed into one vector so a single synchroniser serves them all.
   logic [NSTRAP-1:0] pins_raw;
   logic [NSTRAP-1:0] pins_sync;

   assign pins_raw = {far_end_fault, crossover_enable, prog_if_select,
                      priority_buffer_reserve, port9_if_select, tag_priority_enable,
                      strap_p9_reserved, strap_p9_flow, strap_p9_duplex, strap_p9_speed,
                      strap_back_pressure, strap_frame_len, strap_addr_aging,
                      strap_buffer_share, strap_bcast_storm, strap_flow_ctrl,
                      strap_collision_retry, strap_backoff_aggr,
                      strap_duplex, strap_speed, strap_an};

   strap_sync #(
      .WIDTH    (NSTRAP)
   ) u_sync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   // Sequencer state; the settle count lets synchronised values land first.
   strap_pkg::latch_state_t state_q;
   strap_pkg::latch_state_t state_d;
   logic [3:0]              settle_q;
   logic [3:0]              settle_d;
   logic [NSTRAP-1:0]       snap_q;
   logic [NSTRAP-1:0]       snap_d;
   logic [3:0]              ovr_q;
   logic [3:0]              ovr_d;
   logic                    ack_q;
   logic                    ack_d;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic [1:0]              resp_q;
   logic [1:0]              resp_d;

   // The internal reset is the active-high pin; the snapshot holds defaults while it holds.
   // After release the pins settle through the synchroniser, then freeze.
   always_comb
   begin
      state_d  = state_q;
      settle_d = settle_q;
      snap_d   = snap_q;
      unique case (state_q)
         strap_pkg::ST_RESET:
         begin
            snap_d   = pins_sync;
            settle_d = 4'(SETTLE);
            state_d  = strap_pkg::ST_SETTLE;
         end
         strap_pkg::ST_SETTLE:
         begin
            snap_d = pins_sync;
            if (settle_q == 4'h0)
            begin
               state_d = strap_pkg::ST_RUN;
            end
            else
            begin
               settle_d = settle_q - 4'h1;
            end
         end
         strap_pkg::ST_RUN:
         begin
            snap_d = snap_q;
         end
         default:
         begin
            state_d = strap_pkg::ST_RESET;
         end
      endcase
   end

   // Snapshot resets to all ones, the float/pull-up default of every strap.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q  <= strap_pkg::ST_RESET;
         settle_q <= 4'h0;
         snap_q   <= '1;
      end
      else
      begin
         state_q  <= state_d;
         settle_q <= settle_d;
         snap_q   <= snap_d;
      end
   end

   // Shared pins stay released until the snapshot is frozen.
   assign config_valid  = (state_q == strap_pkg::ST_RUN);
   assign strap_pins_oe = (state_q == strap_pkg::ST_RUN);

   // Field views of the snapshot.
   logic [PORTS-1:0] s_an;
   logic [PORTS-1:0] s_speed;
   logic [PORTS-1:0] s_duplex;
   logic [18:0]      s_misc;

   assign s_an     = snap_q[PORTS-1:0];
   assign s_speed  = snap_q[2*PORTS-1:PORTS];
   assign s_duplex = snap_q[3*PORTS-1:2*PORTS];
   assign s_misc   = snap_q[NSTRAP-1:3*PORTS];

   // Per-port modes; a pull-down reads as low and selects the alternative.
   assign port_an_en = s_an;
   assign port_speed_100 = s_speed | s_an;
   assign port_full_duplex = ~s_duplex & (~s_an | ~partner_negotiates);

   // Switch-wide settings.
   assign backoff_aggressive = s_misc[0];
   assign retry_unlimited    = s_misc[1];
   assign collision_limit    = `RETRY_LIMIT;
   assign flow_ctrl_en       = s_misc[2];
   assign bcast_unlimited    = s_misc[3];
   assign bcast_limit_pct    = `BCAST_LIMIT_PCT;
   assign buffers_per_port   = s_misc[4] ? `BUF_SHARED : `BUF_EQUAL;
   assign aging_en           = s_misc[5];
   assign aging_minutes      = `AGING_MINUTES;
   assign frame_max_tagged   = s_misc[6] ? `FRAME_MAX_LONG : `FRAME_MAX_TAGGED;
   assign frame_max_untagged = s_misc[6] ? `FRAME_MAX_LONG : `FRAME_MAX_UNTAGGED;
   assign back_pressure_en   = s_misc[7];

   // Ninth port; note duplex and flow polarity differ from ports 1 to 8.
   assign p9_speed_100     = s_misc[8];
   assign p9_full_duplex   = s_misc[9];
   assign p9_flow_en       = ~s_misc[10];
   assign p9_reserved_mode = ~s_misc[11];

   // Control pins, with EEPROM overrides taking precedence where allowed.
   assign tag_priority_use = ovr_q[`OV_TAGPRI_EN_BIT] ? ovr_q[`OV_TAGPRI_VAL_BIT]
                                                      : s_misc[12];
   assign priority_high_min = `PRI_HIGH_MIN;
   assign port9_mode = strap_pkg::port9_if_t'(s_misc[14:13]);
   assign seven_wire_serial_if = (port9_mode == strap_pkg::IF_SERIAL7);
   logic priority_buffer_reserve_on;
   assign priority_buffer_reserve_on = ovr_q[`OV_PRIORITY_BUFFER_RESERVE_EN_BIT] ? ovr_q[`OV_PRIORITY_BUFFER_RESERVE_VAL_BIT] : s_misc[15];
   assign priority_reserve_kb = priority_buffer_reserve_on ? `PRIORITY_BUFFER_RESERVE_KBYTES : 4'h0;
   assign prog_if_eeprom    = s_misc[16];
   assign crossover_auto    = s_misc[17];
   assign far_end_fault_dis = s_misc[18];

   // Register images built once for the read mux.
   logic [31:0] port_word;
   logic [31:0] sw_word;
   logic [31:0] pc_word;

   always_comb
   begin
      port_word = 32'h0;
      port_word[`PORT_AN_LSB +: PORTS]     = port_an_en;
      port_word[`PORT_SPEED_LSB +: PORTS]  = port_speed_100;
      port_word[`PORT_DUPLEX_LSB +: PORTS] = port_full_duplex;
      sw_word = 32'h0;
      sw_word[`SW_BACKOFF_BIT]   = backoff_aggressive;
      sw_word[`SW_RETRY_BIT]     = retry_unlimited;
      sw_word[`SW_FLOW_BIT]      = flow_ctrl_en;
      sw_word[`SW_BCAST_BIT]     = bcast_unlimited;
      sw_word[`SW_BUFSHARE_BIT]  = s_misc[4];
      sw_word[`SW_AGING_BIT]     = aging_en;
      sw_word[`SW_FRAMELEN_BIT]  = s_misc[6];
      sw_word[`SW_BACKPR_BIT]    = back_pressure_en;
      sw_word[`SW_P9_SPEED_BIT]  = p9_speed_100;
      sw_word[`SW_P9_DUPLEX_BIT] = p9_full_duplex;
      sw_word[`SW_P9_FLOW_BIT]   = p9_flow_en;
      pc_word = 32'h0;
      pc_word[`PC_TAGPRI_BIT]     = tag_priority_use;
      pc_word[`PC_IFSEL_LSB +: 2] = port9_mode;
      pc_word[`PC_PRIORITY_BUFFER_RESERVE_BIT]       = priority_buffer_reserve_on;
      pc_word[`PC_PROGIF_BIT]     = prog_if_eeprom;
      pc_word[`PC_XOVER_BIT]      = crossover_auto;
      pc_word[`PC_FEF_DIS_BIT]    = far_end_fault_dis;
   end

   // Applies byte enables to the low byte of the override register.
   function automatic logic [3:0] merge_low(input logic [3:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      merge_low = be[0] ? wd[3:0] : old_v;
   endfunction

   // Bus slave: one wait cycle, then a one-cycle answer; unmapped gives slave error.
   always_comb
   begin
      ack_d   = 1'b0;
      ovr_d   = ovr_q;
      rdata_d = rdata_q;
      resp_d  = resp_q;
      if ((avs_read || avs_write) && !ack_q)
      begin
         ack_d   = 1'b1;
         resp_d  = 2'b00;
         rdata_d = 32'h0;
         unique case (avs_address[4:2])
            3'h0: rdata_d = {30'h0, p9_reserved_mode, config_valid};
            3'h1: rdata_d = port_word;
            3'h2: rdata_d = sw_word;
            3'h3: rdata_d = pc_word;
            3'h4:
            begin
               rdata_d = {28'h0, ovr_q};
            end
            3'h5: rdata_d = DEVICE_ID;
            default: resp_d = 2'b10;
         endcase
         if (avs_write)
         begin
            rdata_d = 32'h0;
         end
      end
      // A write lands only at the edge where the master sees waitrequest low,
      // so a request still waiting never changes the override bits.
      if (avs_write && ack_q && (avs_address[4:2] == 3'h4))
      begin
         ovr_d = merge_low(ovr_q, avs_writedata, avs_byteenable);
      end
   end

   // Bus registers; the override bits stand in for the EEPROM's precedence.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ack_q   <= 1'b0;
         ovr_q   <= 4'h0;
         rdata_q <= 32'h0;
         resp_q  <= 2'b00;
      end
      else
      begin
         ack_q   <= ack_d;
         ovr_q   <= ovr_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
      end
   end

   // Waitrequest is combinational so the answer costs only one wait cycle.
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata    = rdata_q;
   assign avs_response    = resp_q;
endmodule

// [tb/strap_board.sv]
// Board strapping model that feeds the shared configuration pins.
`timescale 1ns/100ps
module strap_board (
   input  wire logic [42:0] cfg,
   input  wire logic        oe,
   output logic      [42:0] pins
);
   // Resistors set the level in reset; once the device drives the pins they show LED traffic.
   // The inverse is shown then so any late resampling is caught at once.
   assign pins = oe ? ~cfg : cfg;
endmodule

// [tb/reset_strap_config_latch_chk.sv]
// Concurrent checks on the strap latch top-level ports.
`timescale 1ns/100ps
module reset_strap_config_latch_chk #(
   parameter int PORTS = 8
) (
   input wire logic             clock,
   input wire logic             sys_rst,
   input wire logic             strap_pins_oe,
   input wire logic             config_valid,
   input wire logic [PORTS-1:0] partner_negotiates,
   input wire logic [PORTS-1:0] port_an_en,
   input wire logic [PORTS-1:0] port_speed_100,
   input wire logic [PORTS-1:0] port_full_duplex,
   input wire logic             retry_unlimited,
   input wire logic [4:0]       collision_limit,
   input wire logic [9:0]       buffers_per_port,
   input wire logic [10:0]      frame_max_tagged,
   input wire logic [10:0]      frame_max_untagged,
   input strap_pkg::port9_if_t  port9_mode,
   input wire logic             seven_wire_serial_if
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   // The first edge out of reset starts the settle count.
   sequence s_release;
      $past(sys_rst) && !sys_rst;
   endsequence
   sequence s_settling;
      !config_valid [*4] ##1 config_valid;
   endsequence

   // Pins may only be driven once the snapshot is frozen, and it stays frozen.
   a_oe_tracks_valid: assert property (strap_pins_oe == config_valid)
      else $error("strap pins driven while not frozen");
   a_valid_holds: assert property (config_valid |=> config_valid)
      else $error("frozen flag dropped without reset");
   a_config_frozen: assert property (config_valid && $past(config_valid) |->
      $stable(port_an_en) && $stable(buffers_per_port) && $stable(port9_mode))
      else $error("configuration moved after freeze");
   a_release_timing: assert property (s_release |-> s_settling)
      else $error("freeze not at the settled edge");
   // Decoded outputs must agree with each other.
   a_speed_forced: assert property ((port_an_en & ~port_speed_100) == '0)
      else $error("negotiating port not at 100");
   a_duplex_negotiated: assert property ((port_full_duplex & port_an_en & partner_negotiates) == '0)
      else $error("duplex strap used with negotiating partner");
   a_retry_count: assert property (!retry_unlimited |-> collision_limit == 5'h10)
      else $error("collision limit wrong");
   a_frame_pair: assert property (frame_max_tagged == 11'h600 |-> frame_max_untagged == 11'h600)
      else $error("frame limits disagree");
   a_serial_flag: assert property (seven_wire_serial_if == (port9_mode == strap_pkg::IF_SERIAL7))
      else $error("serial flag disagrees with mode");
endmodule

bind reset_strap_config_latch reset_strap_config_latch_chk #(.PORTS(PORTS)) u_chk (
   .clock(clock), .sys_rst(sys_rst), .strap_pins_oe(strap_pins_oe), .config_valid(config_valid),
   .partner_negotiates(partner_negotiates), .port_an_en(port_an_en),
   .port_speed_100(port_speed_100), .port_full_duplex(port_full_duplex),
   .retry_unlimited(retry_unlimited), .collision_limit(collision_limit),
   .buffers_per_port(buffers_per_port), .frame_max_tagged(frame_max_tagged),
   .frame_max_untagged(frame_max_untagged), .port9_mode(port9_mode),
   .seven_wire_serial_if(seven_wire_serial_if));

// [tb/reset_strap_config_latch_bench.sv]
// Self-checking bench for the reset strap configuration latch.
`timescale 1ns/100ps
module reset_strap_config_latch_bench;
   typedef struct packed {logic [42:0] c; logic [7:0] pn; logic [7:0] spd; logic [7:0] dup;} row_t;
   logic        clock, sys_rst, avs_read, avs_write, oe, cv, swif, tpu, pifee, xauto, fefd;
   logic [4:0]  avs_address, climit;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable, amin, prkb;
   logic [1:0]  avs_response, rs;
   logic        avs_waitrequest;
   logic [42:0] cfg, pins;
   logic [7:0]  pn, an_en, spd100, fdup;
   logic        boff, runl, flow, bunl, agen, bpen, p9s, p9d, p9f, p9r;
   logic [6:0]  bpct;
   logic [9:0]  bufs;
   logic [10:0] ftag, funt;
   logic [2:0]  phm;
   strap_pkg::port9_if_t p9mode;
   int          fail_count, check_count;
   row_t        rows[5];

   strap_board board (.cfg(cfg), .oe(oe), .pins(pins));

   reset_strap_config_latch dut (
      .clock(clock), .sys_rst(sys_rst), .strap_an(pins[42:35]), .strap_speed(pins[34:27]),
      .strap_duplex(pins[26:19]), .strap_backoff_aggr(pins[8]), .strap_collision_retry(pins[9]),
      .strap_flow_ctrl(pins[10]), .strap_bcast_storm(pins[11]), .strap_buffer_share(pins[12]),
      .strap_addr_aging(pins[13]), .strap_frame_len(pins[14]), .strap_back_pressure(pins[15]),
      .strap_p9_speed(pins[16]), .strap_p9_duplex(pins[17]), .strap_p9_flow(pins[18]),
      .strap_p9_reserved(pins[7]), .tag_priority_enable(pins[6]), .port9_if_select(pins[5:4]),
      .priority_buffer_reserve(pins[3]), .prog_if_select(pins[2]), .crossover_enable(pins[1]),
      .far_end_fault(pins[0]), .partner_negotiates(pn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .strap_pins_oe(oe),
      .config_valid(cv), .port_an_en(an_en), .port_speed_100(spd100), .port_full_duplex(fdup),
      .backoff_aggressive(boff), .retry_unlimited(runl), .collision_limit(climit),
      .flow_ctrl_en(flow), .bcast_unlimited(bunl), .bcast_limit_pct(bpct),
      .buffers_per_port(bufs), .aging_en(agen), .aging_minutes(amin), .frame_max_tagged(ftag),
      .frame_max_untagged(funt), .back_pressure_en(bpen), .p9_speed_100(p9s),
      .p9_full_duplex(p9d), .p9_flow_en(p9f), .p9_reserved_mode(p9r), .tag_priority_use(tpu),
      .priority_high_min(phm), .port9_mode(p9mode), .seven_wire_serial_if(swif),
      .priority_reserve_kb(prkb), .prog_if_eeprom(pifee), .crossover_auto(xauto),
      .far_end_fault_dis(fefd));

   // Free-running 10 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Prints the verdict and ends the run.
   task give_verdict;
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One comparison; a mismatch is reported at once.
   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // Bus cycle held until the rising edge that samples waitrequest low; data taken there.
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            chk(1'b0, "bus timeout");
            give_verdict();
         end
         @(posedge clock);
      end
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask

   // Reset with new straps for ten cycles, then wait for the freeze.
   task do_reset(input logic [42:0] c, input logic [7:0] p);
      int n;
      @(posedge clock);
      sys_rst <= 1'b1;
      cfg <= c;
      pn <= p;
      repeat (10) @(posedge clock);
      chk(cv === 1'b0 && oe === 1'b0, "pins driven in reset");
      sys_rst <= 1'b0;
      n = 0;
      @(negedge clock);
      while (cv !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            chk(1'b0, "freeze timeout");
            give_verdict();
         end
         @(negedge clock);
      end
      chk(oe === 1'b1, "pins not released after freeze");
      repeat (5) @(posedge clock);
   endtask

   // Expected decode of every output, worked out from the strap row.
   task check_row(input row_t r);
      logic [10:0] s;
      s = r.c[18:8];
      chk(spd100 === r.spd, "speed");
      chk(fdup === r.dup, "duplex");
      chk({p9f, p9d, p9s, bpen, agen, bunl, flow, runl, boff} === {~s[10], s[9:7], s[5], s[3:0]}, "sw");
      chk(ftag === (s[6] ? 11'h600 : 11'h5f2), "tagged");
      chk(funt === (s[6] ? 11'h600 : 11'h5ee), "untagged");
      chk(bufs === (s[4] ? 10'h200 : 10'h071), "buffers");
      chk({climit, bpct, amin, phm} === {5'h10, 7'h05, 4'h5, 3'h4}, "limits");
      chk({an_en, p9mode, swif, tpu} === {r.c[42:35], r.c[5:4], &r.c[5:4], r.c[6]}, "pins");
      chk({prkb, pifee, xauto, fefd, p9r} === {r.c[3] ? 4'h6 : 4'h0, r.c[2:0], ~r.c[7]}, "ctl");
   endtask

   // Main sequence: table of strap sets, then registers and overrides.
   initial
   begin
      sys_rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      cfg = '1;
      pn = 8'h00;
      fail_count = 0;
      check_count = 0;
      // The lowest port 9 strap stays high except in the row that probes it.
      rows[0] = '{43'h7ff_ffff_ffff, 8'hff, 8'hff, 8'h00};
      rows[1] = '{43'h000_0000_0080, 8'h00, 8'h00, 8'hff};
      rows[2] = '{{8'h0f, 8'ha5, 8'h3c, 11'h555, 4'b1001, 4'b1010}, 8'h33, 8'haf, 8'hc0};
      rows[3] = '{{8'hf0, 8'h00, 8'h00, 11'h2aa, 4'b1110, 4'b0101}, 8'hff, 8'hf0, 8'h0f};
      rows[4] = '{{8'h55, 8'h0f, 8'hf0, 11'h7ff, 4'b0011, 4'b0011}, 8'haa, 8'h5f, 8'h0f};
      foreach (rows[i])
      begin
         do_reset(rows[i].c, rows[i].pn);
         check_row(rows[i]);
      end
      do_reset(rows[0].c, rows[0].pn);
      bus(1'b0, 5'h00, 32'h0);
      chk(rd === 32'h1, "status");
      bus(1'b0, 5'h04, 32'h0);
      chk(rd === 32'h0000_ffff, "port word");
      bus(1'b1, 5'h08, 32'h0);
      bus(1'b0, 5'h08, 32'h0);
      chk({rs, rd} === {2'b00, 32'h3ff}, "switch word");
      bus(1'b0, 5'h18, 32'h0);
      chk({rs, rd} === {2'b10, 32'h0}, "unmapped");
      bus(1'b1, 5'h10, 32'h5);
      bus(1'b0, 5'h10, 32'h0);
      chk({rd, tpu, prkb} === {32'h5, 1'b0, 4'h0}, "override off");
      do_reset(rows[1].c, rows[1].pn);
      bus(1'b1, 5'h10, 32'hf);
      chk({tpu, prkb} === {1'b1, 4'h6}, "override on");
      avs_byteenable <= 4'he;
      bus(1'b1, 5'h10, 32'h0);
      avs_byteenable <= 4'hf;
      chk({tpu, prkb} === {1'b1, 4'h6}, "masked lane written");
      do_reset(rows[1].c, rows[1].pn);
      bus(1'b0, 5'h10, 32'h0);
      chk({rd, tpu, prkb} === {32'h0, 1'b0, 4'h0}, "override reset");
      give_verdict();
   end
endmodule
